/* File: sfr_pkg.sv */
// Package for the stepper fault and reset logic: types, codes and timing counts.
// Assumes a single 25 MHz system clock; analog levels are carried as codes.
package sfr_pkg;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int unsigned CLK_HZ          = 25_000_000;   // System clock rate
    localparam int unsigned BLANK_NS        = 1250;         // Blanking after chop turn-on
    // Least time, rounded up to whole cycles
    localparam int unsigned BLANK_CYC       = (BLANK_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned STEP_GAP_US     = 10;           // Host wait after reset release
    localparam int unsigned STEP_GAP_CYC    = STEP_GAP_US * (CLK_HZ / 1_000_000);
    localparam int unsigned BLANK_W         = 6;            // Blank counter width

    // ****************************************************************
    // Fault-kind output codes (two levels plus none)
    // ****************************************************************
    typedef enum logic [1:0] {
        SFR_KIND_NONE = 2'h0,   // No fault: line released
        SFR_KIND_OC   = 2'h1,   // Overcurrent level (~2.5 V)
        SFR_KIND_OH   = 2'h2    // Overheat level (~3.3 V)
    } sfr_kind_t;

    // Detector inputs travel together
    typedef struct packed {
        logic over_current;     // Current comparator above threshold
        logic over_heat;        // Substrate sensor above threshold
    } sfr_det_t;

    // Reset values
    localparam logic       RST_LATCH = 1'b0;
    localparam logic [3:0] RST_DRIVE = 4'h0;
    localparam logic [1:0] RST_MON   = 2'h0;

endpackage : sfr_pkg

/* File: sfr_sync.sv */
// Two-flop synchroniser for a group of asynchronous level inputs.
// Assumes the destination clock is clk_sys_i; no reset on the chain.
`timescale 1ns/1ns
`default_nettype none
module sfr_sync #(
    parameter int unsigned W = 2                // Number of bits
) (
    input  wire logic         clk_sys_i,        // System clock
    input  wire logic [W-1:0] d_i,              // Asynchronous inputs
    output logic      [W-1:0] q_o               // Synchronised outputs
);
    // ****************************************************************
    // Per-bit chain
    // ****************************************************************
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            logic meta_q;                       // First stage, read only by second
            logic sync_q;                       // Second stage
            // First stage only feeds second, keeps metastability contained
            always_ff @(posedge clk_sys_i) begin
                meta_q <= d_i[g];
                sync_q <= meta_q;
            end
            assign q_o[g] = sync_q;
        end
    endgenerate
endmodule : sfr_sync
`default_nettype wire

/* File: sfr_top.sv */
// Fault latch, reset combine and drive gating for a two-phase stepper driver.
// Assumes detectors, reset pin and enable pin arrive asynchronously; the
// analog power-on detector supplies por_ok_i once the logic rail is near 4 V.
`timescale 1ns/1ns
`default_nettype none

module sfr_top (
    input  wire logic       clk_sys_i,          // 25 MHz system clock
    input  wire logic       rstn_i,             // Synchronous reset, active low
    input  wire logic       por_ok_i,           // Supply above POR threshold
    input  wire logic       system_reset_n_i,   // External reset pin, active low
    input  wire logic       enable_i,           // Drive enable pin
    input  wire logic       chop_on_i,          // Chopper turn-on strobe level
    input  wire logic       over_current_i,     // Current comparator (5 A trip)
    input  wire logic       over_heat_i,        // Substrate sensor (144 C trip)
    input  wire logic [3:0] phase_drive_i,      // Drive request from distributor
    input  wire logic       phase_step_i,       // One pulse per phase step
    input  wire logic [1:0] mode_div_i,         // Monitor divide (log2 steps)
    output logic      [3:0] drive_o,            // Gated excitation drive
    output logic            fault_flag_n_o,     // Open-drain data, always low
    output logic            fault_flag_n_oe_o,  // High while pulling low
    output sfr_pkg::sfr_kind_t fault_kind_level_o, // Fault kind code
    output logic            excitation_monitor_o, // Excitation monitor
    output logic            sys_reset_n_o       // Combined reset, active low
);

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    sfr_pkg::sfr_det_t det_raw;                 // Raw detector group
    sfr_pkg::sfr_det_t det_s;                   // Synchronised detectors
    logic [4:0]        sync_in;                 // Async levels except the chop strobe
    logic [4:0]        sync_out;                // After two flops
    logic              por_ok_s;                // Supply good, synced
    logic              ext_rst_n_s;             // External reset, synced
    logic              enable_s;                // Enable, synced

    assign det_raw.over_current = over_current_i;
    assign det_raw.over_heat    = over_heat_i;
    assign sync_in = {enable_i, system_reset_n_i, por_ok_i, det_raw};

    // Detectors pass two flops before the latches
    sfr_sync #(
        .W (5)
    ) u_sync (
        .clk_sys_i (clk_sys_i),
        .d_i       (sync_in),
        .q_o       (sync_out)
    );

    assign det_s       = sync_out[1:0];
    assign por_ok_s    = sync_out[2];
    assign ext_rst_n_s = sync_out[3];
    assign enable_s    = sync_out[4];

    // ****************************************************************
    // Reset combine
    // ****************************************************************
    logic rst_int;                              // Internal reset, active high
    // Any of the three sources alone resets the latches, counters and outputs
    // POR held while supply below ~4 V
    assign rst_int = !rstn_i || !por_ok_s || !ext_rst_n_s;

    // Registered so the output comes from a flop
    always_ff @(posedge clk_sys_i) begin
        sys_reset_n_o <= !rst_int;
    end

    // ****************************************************************
    // Overcurrent blanking after chop turn-on
    // ****************************************************************
    logic               chop_s1_q;              // First sync stage
    logic               chop_s2_q;              // Second sync stage
    logic               chop_d_q;               // Delayed for edge detect
    logic [sfr_pkg::BLANK_W-1:0] blank_q;       // Blank cycles remaining
    logic               chop_rise;              // Turn-on event
    logic               oc_valid;               // Comparator may be trusted

    // Chop strobe is also asynchronous
    always_ff @(posedge clk_sys_i) begin
        chop_s1_q <= chop_on_i;
        chop_s2_q <= chop_s1_q;
        chop_d_q  <= chop_s2_q;
    end

    assign chop_rise = chop_s2_q && !chop_d_q;

    // Reload at every turn-on while enabled; counts down to zero
    always_ff @(posedge clk_sys_i) begin
        if (rst_int) begin
            blank_q <= '0;
        end else if (!enable_s) begin
            blank_q <= blank_q;                 // Count frozen while disabled
        end else if (chop_rise) begin
            blank_q <= sfr_pkg::BLANK_W'(sfr_pkg::BLANK_CYC);
        end else if (blank_q != '0) begin
            blank_q <= blank_q - 1'b1;
        end
    end

    // Ringing can exceed the trip briefly, so the turn-on cycle is also masked
    assign oc_valid = (blank_q == '0) && !chop_rise;

    // ****************************************************************
    // Fault latches
    // ****************************************************************
    logic oc_latch_q;                           // Overcurrent tripped
    logic oh_latch_q;                           // Overheat tripped

    // Overcurrent latch; threshold is in the analog comparator
    always_ff @(posedge clk_sys_i) begin
        if (rst_int) begin
            oc_latch_q <= sfr_pkg::RST_LATCH;
        end else if (enable_s && det_s.over_current && oc_valid) begin
            oc_latch_q <= 1'b1;
        end
    end

    // Overheat latch from substrate sensor
    always_ff @(posedge clk_sys_i) begin
        if (rst_int) begin
            oh_latch_q <= sfr_pkg::RST_LATCH;
        end else if (enable_s && det_s.over_heat) begin
            oh_latch_q <= 1'b1;
        end
    end

    // ****************************************************************
    // Fault outputs
    // ****************************************************************
    logic any_fault;                            // Either latch set
    assign any_fault = oc_latch_q || oh_latch_q;

    // Open drain: data always low, enable while faulted
    always_ff @(posedge clk_sys_i) begin
        fault_flag_n_o <= 1'b0;
        if (rst_int) begin
            fault_flag_n_oe_o <= 1'b0;
        end else begin
            fault_flag_n_oe_o <= any_fault;
        end
    end

    // Kind code; overcurrent wins if both, first trip usually cuts current
    always_ff @(posedge clk_sys_i) begin
        if (rst_int) begin
            fault_kind_level_o <= sfr_pkg::SFR_KIND_NONE;
        end else if (oc_latch_q) begin
            fault_kind_level_o <= sfr_pkg::SFR_KIND_OC;
        end else if (oh_latch_q) begin
            fault_kind_level_o <= sfr_pkg::SFR_KIND_OH;
        end else begin
            fault_kind_level_o <= sfr_pkg::SFR_KIND_NONE;
        end
    end

    // ****************************************************************
    // Drive gating
    // ****************************************************************
    // Latch or disable forces every phase off
    always_ff @(posedge clk_sys_i) begin
        if (rst_int) begin
            drive_o <= sfr_pkg::RST_DRIVE;
        end else if (!enable_s) begin
            drive_o <= sfr_pkg::RST_DRIVE;
        end else if (any_fault) begin
            drive_o <= sfr_pkg::RST_DRIVE;
        end else begin
            drive_o <= phase_drive_i;
        end
    end

    // ****************************************************************
    // Excitation monitor
    // ****************************************************************
    logic [3:0] mon_cnt_q;                      // Step counter
    logic [3:0] mon_top;                        // Wrap value per mode

    // Finer modes take more steps per monitor half period
    assign mon_top = 4'((4'h1 << mode_div_i) - 4'h1);

    // Toggle when the per-mode step count wraps
    always_ff @(posedge clk_sys_i) begin
        if (rst_int) begin
            mon_cnt_q            <= 4'h0;
            excitation_monitor_o <= 1'b0;
        end else if (enable_s && phase_step_i) begin
            if (mon_cnt_q >= mon_top) begin
                mon_cnt_q            <= 4'h0;
                excitation_monitor_o <= !excitation_monitor_o;
            end else begin
                mon_cnt_q <= mon_cnt_q + 4'h1;
            end
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_drive_off_fault: assert property (@(posedge clk_sys_i) disable iff (rst_int)
        any_fault |=> (drive_o == 4'h0))
        else $error("drive active after fault");

    a_flag_follows_fault: assert property (@(posedge clk_sys_i) disable iff (rst_int)
        any_fault |=> fault_flag_n_oe_o)
        else $error("flag not pulled low");

    a_latch_holds: assert property (@(posedge clk_sys_i)
        (oc_latch_q && !rst_int) |=> (oc_latch_q || $past(rst_int) || rst_int))
        else $error("overcurrent latch lost");

    a_blank_masks_oc: assert property (@(posedge clk_sys_i) disable iff (rst_int)
        (!oc_latch_q && blank_q != '0) |=> !oc_latch_q)
        else $error("overcurrent during blanking");

    a_blank_length: assert property (@(posedge clk_sys_i) disable iff (rst_int)
        (chop_rise && enable_s) |=> (blank_q == sfr_pkg::BLANK_W'(sfr_pkg::BLANK_CYC)))
        else $error("blank count wrong");

    a_kind_oc: assert property (@(posedge clk_sys_i) disable iff (rst_int)
        oc_latch_q |=> (fault_kind_level_o == sfr_pkg::SFR_KIND_OC))
        else $error("kind not overcurrent");

    a_kind_oh: assert property (@(posedge clk_sys_i) disable iff (rst_int)
        (oh_latch_q && !oc_latch_q) |=> (fault_kind_level_o == sfr_pkg::SFR_KIND_OH))
        else $error("kind not overheat");

    a_reset_clears: assert property (@(posedge clk_sys_i)
        rst_int |=> (!oc_latch_q && !oh_latch_q && fault_kind_level_o == sfr_pkg::SFR_KIND_NONE))
        else $error("reset left fault");

    a_disable_off: assert property (@(posedge clk_sys_i) disable iff (rst_int)
        !enable_s |=> (drive_o == 4'h0))
        else $error("drive active while disabled");

    a_ext_reset: assert property (@(posedge clk_sys_i)
        (!ext_rst_n_s || !por_ok_s) |=> !sys_reset_n_o)
        else $error("reset source ignored");

    a_oh_sets: assert property (@(posedge clk_sys_i) disable iff (rst_int)
        (enable_s && det_s.over_heat) |=> oh_latch_q)
        else $error("overheat not latched");

endmodule : sfr_top
`default_nettype wire

/* File: sfr_host_model.sv */
// Host controller model: drives enable, the reset pin and step pulses.
// Assumes the bench requests actions at the falling edge; reset and step outputs move on the rising edge, enable at once.
`timescale 1ns/1ns
`default_nettype none
module sfr_host_model (
    input  wire logic clk_sys_i,   // System clock
    input  wire logic por_ok_i,    // Supply above threshold
    input  wire logic run_i,       // Bench wants the drive on
    input  wire logic rst_req_i,   // Request one reset pulse
    input  wire logic step_req_i,  // Request step pulses
    output logic      enable_o,    // Enable pin
    output logic      reset_n_o,   // Reset pin, active low
    output logic      step_o       // One-cycle step pulse
);
    // ****************************************************************
    // State
    // ****************************************************************
    logic [2:0] rst_cnt_q = 3'h0;  // Reset pulse length left
    logic [8:0] gap_q     = 9'h0;  // Wait left before stepping

    // Enable held low while the supply is short
    assign enable_o  = run_i & por_ok_i;
    // Pin goes high, low, high again
    assign reset_n_o = (rst_cnt_q == 3'h0);

    // Reset pulse of four cycles
    always @(posedge clk_sys_i) begin
        if (rst_req_i && rst_cnt_q == 3'h0) begin
            rst_cnt_q <= 3'h4;
        end else if (rst_cnt_q != 3'h0) begin
            rst_cnt_q <= rst_cnt_q - 3'h1;
        end
    end

    // No step edge until the gap after reset release has run out
    always @(posedge clk_sys_i) begin
        if (rst_cnt_q == 3'h1) begin
            gap_q <= 9'(sfr_pkg::STEP_GAP_CYC);
        end else if (gap_q != 9'h0) begin
            gap_q <= gap_q - 9'h1;
        end
        // No step at all while the pin is held low
        step_o <= step_req_i && gap_q == 9'h0 && rst_cnt_q == 3'h0 && !step_o;
    end
endmodule : sfr_host_model
`default_nettype wire

/* File: sfr_top_tb_top.sv */
// Self-checking bench for the stepper fault and reset logic.
// Assumes sfr_pkg, sfr_sync, sfr_top and sfr_host_model are compiled first.
`timescale 1ns/1ns
`default_nettype none
module sfr_top_tb_top;
    // ****************************************************************
    // Signals
    // ****************************************************************
    logic               clk_sys_i = 1'b0;  // 25 MHz clock
    logic               rstn_i    = 1'b0;  // Bench reset
    logic               por_ok_i  = 1'b1;  // Supply good
    logic               run       = 1'b1;  // Drive wanted
    logic               rst_req   = 1'b0;  // Pin reset request
    logic               step_req  = 1'b0;  // Step request
    logic               chop_on_i = 1'b0;  // Chopper level
    sfr_pkg::sfr_det_t  det       = '0;    // Detector levels
    logic [3:0]         phase_drive_i = 4'h9;  // Drive request
    logic [1:0]         mode_div_i    = 2'h1;  // Toggle every two steps
    logic               enable, pin_rst_n, step;  // Host outputs
    logic [3:0]         drive_o;   // Gated drive
    logic               flag_n, flag_oe, mon_o, sys_rst_n;  // Status
    sfr_pkg::sfr_kind_t kind;      // Fault kind
    int                 fails = 0, num_checks = 0, cycles = 0;

    always #20 clk_sys_i = ~clk_sys_i;

    sfr_host_model u_host (.clk_sys_i(clk_sys_i), .por_ok_i(por_ok_i), .run_i(run), .rst_req_i(rst_req),
        .step_req_i(step_req), .enable_o(enable), .reset_n_o(pin_rst_n), .step_o(step));
    sfr_top u_dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .por_ok_i(por_ok_i), .system_reset_n_i(pin_rst_n),
        .enable_i(enable), .chop_on_i(chop_on_i), .over_current_i(det.over_current), .over_heat_i(det.over_heat),
        .phase_drive_i(phase_drive_i), .phase_step_i(step), .mode_div_i(mode_div_i), .drive_o(drive_o),
        .fault_flag_n_o(flag_n), .fault_flag_n_oe_o(flag_oe), .fault_kind_level_o(kind),
        .excitation_monitor_o(mon_o), .sys_reset_n_o(sys_rst_n));

    // ****************************************************************
    // Helpers
    // ****************************************************************
    task automatic wait_n(input int n);
        repeat (n) @(negedge clk_sys_i);
    endtask : wait_n

    // Four-state compare; an unknown matches only an unknown
    task automatic chk(input logic [3:0] got, input logic [3:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    // Fault state in one call: flag enable, kind, drive
    task automatic chk_fault(input logic oe, input logic [1:0] k, input logic [3:0] drv);
        chk({3'h0, flag_oe}, {3'h0, oe}, "flag enable");
        chk({2'h0, kind}, {2'h0, k}, "fault kind");
        chk(drive_o, drv, "drive");
    endtask : chk_fault

    task automatic step_pulse;
        step_req = 1'b1;
        wait_n(1);
        step_req = 1'b0;
        wait_n(3);
    endtask : step_pulse

    task automatic tally_and_finish;
        if (fails == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : tally_and_finish

    // Hang guard, well past the longest sequence
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            tally_and_finish();
        end
    end

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_reset_values;
        chk_fault(1'b0, sfr_pkg::SFR_KIND_NONE, 4'h0);
        chk({3'h0, sys_rst_n}, 4'h0, "combined reset held");
        rstn_i = 1'b1;
        wait_n(6);
        chk({3'h0, sys_rst_n}, 4'h1, "combined reset released");
        chk(drive_o, 4'h9, "drive passes");
        chk({3'h0, flag_n}, 4'h0, "flag data low");
    endtask : t_reset_values

    task automatic t_monitor;
        step_pulse();
        chk({3'h0, mon_o}, 4'h0, "monitor after one step");
        step_pulse();
        chk({3'h0, mon_o}, 4'h1, "monitor after two steps");
        mode_div_i = 2'h0;
        step_pulse();
        chk({3'h0, mon_o}, 4'h0, "monitor every step");
        mode_div_i = 2'h2;
        repeat (3) step_pulse();
        chk({3'h0, mon_o}, 4'h0, "monitor before fourth step");
        step_pulse();
        chk({3'h0, mon_o}, 4'h1, "monitor after four steps");
        mode_div_i = 2'h3;
        repeat (7) step_pulse();
        chk({3'h0, mon_o}, 4'h1, "monitor before eighth step");
        step_pulse();
        chk({3'h0, mon_o}, 4'h0, "monitor after eight steps");
    endtask : t_monitor

    // Overcurrent inside the blanking time is ignored, after it latches
    task automatic t_blank_oc;
        chop_on_i = 1'b1;
        wait_n(4);
        det.over_current = 1'b1;
        wait_n(20);
        det.over_current = 1'b0;
        wait_n(4);
        chk_fault(1'b0, sfr_pkg::SFR_KIND_NONE, 4'h9);
        wait_n(20);
        det.over_current = 1'b1;
        wait_n(6);
        chk_fault(1'b1, sfr_pkg::SFR_KIND_OC, 4'h0);
        det.over_current = 1'b0;
        chop_on_i = 1'b0;
        wait_n(10);
        chk_fault(1'b1, sfr_pkg::SFR_KIND_OC, 4'h0);
    endtask : t_blank_oc

    task automatic t_por_clear;
        por_ok_i = 1'b0;
        wait_n(5);
        chk({3'h0, sys_rst_n}, 4'h0, "supply low resets");
        chk_fault(1'b0, sfr_pkg::SFR_KIND_NONE, 4'h0);
        por_ok_i = 1'b1;
        wait_n(6);
        chk({3'h0, sys_rst_n}, 4'h1, "supply good releases");
    endtask : t_por_clear

    // Overheat holds after the sensor drops, cleared by a pin pulse
    task automatic t_overheat_pin;
        det.over_heat = 1'b1;
        wait_n(6);
        chk_fault(1'b1, sfr_pkg::SFR_KIND_OH, 4'h0);
        det.over_heat = 1'b0;
        wait_n(10);
        chk_fault(1'b1, sfr_pkg::SFR_KIND_OH, 4'h0);
        rst_req = 1'b1;
        wait_n(1);
        rst_req = 1'b0;
        wait_n(4);
        chk({3'h0, sys_rst_n}, 4'h0, "pin reset acts");
        wait_n(6);
        chk_fault(1'b0, sfr_pkg::SFR_KIND_NONE, 4'h9);
    endtask : t_overheat_pin

    // Disabled block drives nothing and takes no fault
    task automatic t_enable_low;
        run = 1'b0;
        wait_n(5);
        chk(drive_o, 4'h0, "drive off when disabled");
        det.over_heat = 1'b1;
        wait_n(6);
        chk_fault(1'b0, sfr_pkg::SFR_KIND_NONE, 4'h0);
        det.over_heat = 1'b0;
        wait_n(4);
        run = 1'b1;
        wait_n(6);
        chk_fault(1'b0, sfr_pkg::SFR_KIND_NONE, 4'h9);
    endtask : t_enable_low

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        wait_n(10);
        t_reset_values();
        t_monitor();
        t_blank_oc();
        t_por_clear();
        t_overheat_pin();
        t_enable_low();
        tally_and_finish();
    end
endmodule : sfr_top_tb_top
`default_nettype wire
